//--- rtl/rhpd_pkg.sv
// shared constants for the root hub port power descriptor registers
package rhpd_pkg;
    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_RD_FIRST = 8'h12;
    localparam logic [7:0] CMD_WR_FIRST = 8'h92;
    localparam logic [7:0] CMD_RD_SECOND = 8'h13;
    localparam logic [7:0] CMD_WR_SECOND = 8'h93;

    // ==========================================================
    // port geometry
    localparam int MAX_PORTS = 2;
    localparam logic [1:0] PORT_COUNT_LIMIT = 2'h2;

    // ==========================================================
    // first descriptor register fields
    localparam int NO_SWITCH_BIT = 9;
    localparam int MODE_SEL_BIT = 8;
    localparam int PORT_COUNT_LSB = 0;
    localparam int PORT_COUNT_W = 2;

    // ==========================================================
    // second descriptor register fields
    localparam int MASK_LSB = 16;
    localparam int REMOVE_LSB = 0;
    localparam int PORT_FIELD_W = 3;

    // ==========================================================
    // implementation-specific reset values
    localparam logic RST_NO_SWITCH = 1'h0;
    localparam logic RST_MODE_SEL = 1'h0;
    localparam logic [2:1] RST_MASK = 2'h0;
    localparam logic [2:1] RST_REMOVE = 2'h0;
    localparam logic [2:1] RST_POWER = 2'h0;
    localparam logic [31:0] RST_RD_DATA = 32'h0;

    // ==========================================================
    // decoded command kinds
    typedef enum logic [2:0] {
        RHPD_CMD_NONE,
        RHPD_CMD_RD_FIRST,
        RHPD_CMD_WR_FIRST,
        RHPD_CMD_RD_SECOND,
        RHPD_CMD_WR_SECOND
    } rhpd_cmd_e;
endpackage

//--- rtl/rhpd_power_if.sv
// configuration and command bundle between register bank and power switch
`timescale 1ns/10ps
interface rhpd_power_if;
    logic no_switch;
    logic mode_sel;
    logic [2:1] mask;
    logic [1:0] port_count;
    logic ganged_on;
    logic ganged_off;
    logic [2:1] port_on;
    logic [2:1] port_off;
    logic [2:1] power;

    // register bank side
    modport regs (
        output no_switch, mode_sel, mask, port_count,
        output ganged_on, ganged_off, port_on, port_off,
        input power
    );

    // power switch side
    modport sw (
        input no_switch, mode_sel, mask, port_count,
        input ganged_on, ganged_off, port_on, port_off,
        output power
    );
endinterface

//--- rtl/rhpd_power_switch.sv
// per-port power state tracking for the root hub ports
`timescale 1ns/10ps
module rhpd_power_switch (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration, commands and power state
    rhpd_power_if.sw pw
);
    logic [2:1] next_power;
    logic [2:1] power;
    logic [2:1] present;

    // ==========================================================
    // per-port next power state
    for (genvar i = 1; i <= rhpd_pkg::MAX_PORTS; i++) begin : g_port
        always_comb begin
            present[i] = (2'(i) <= pw.port_count);
            next_power[i] = power[i];
            if (!present[i]) begin
                next_power[i] = 1'b0;
            end else if (pw.no_switch) begin
                next_power[i] = 1'b1;
            end else if (!pw.mode_sel) begin
                // ganged: mask ignored, per-port commands ignored
                if (pw.ganged_on) begin
                    next_power[i] = 1'b1;
                end else if (pw.ganged_off) begin
                    next_power[i] = 1'b0;
                end
            end else if (pw.mask[i]) begin
                if (pw.port_on[i]) begin
                    next_power[i] = 1'b1;
                end else if (pw.port_off[i]) begin
                    next_power[i] = 1'b0;
                end
            end else begin
                if (pw.ganged_on) begin
                    next_power[i] = 1'b1;
                end else if (pw.ganged_off) begin
                    next_power[i] = 1'b0;
                end
            end
        end

        // masked port ignores global commands
        a_masked_port_hold: assert property (@(posedge clk) disable iff (!arst_n)
            (present[i] && !pw.no_switch && pw.mode_sel && pw.mask[i] && !pw.port_on[i] && !pw.port_off[i])
            |=> $stable(power[i]))
            else $error("masked port changed on a global command");

        // unmasked port ignores per-port commands
        a_unmasked_port_hold: assert property (@(posedge clk) disable iff (!arst_n)
            (present[i] && !pw.no_switch && pw.mode_sel && !pw.mask[i] && !pw.ganged_on && !pw.ganged_off)
            |=> $stable(power[i]))
            else $error("unmasked port changed on a per-port command");
    end

    // power state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power <= rhpd_pkg::RST_POWER;
        end else begin
            power <= next_power;
        end
    end

    assign pw.power = power;

    // ==========================================================
    // checks
    a_always_powered: assert property (@(posedge clk) disable iff (!arst_n)
        pw.no_switch |=> (power == present))
        else $error("ports not powered with switching disabled");

    a_ganged_together: assert property (@(posedge clk) disable iff (!arst_n)
        (!pw.no_switch && !pw.mode_sel && pw.ganged_on) |=> (power == present))
        else $error("ganged power-on did not power all ports");
endmodule

//--- rtl/rhpd_regs.sv
// root hub port power descriptor register bank with command decode
`timescale 1ns/10ps

// How it works
// - no-switching set keeps every implemented port powered from the clock edge after it is set
// - no-switching at bit 9; only when clear does mode select matter
// - mode bit 8 at zero switches all ports together as one group
// - mode bit is ignored whenever no-switching is set
// - per-port mode, masked port follows only per-port power commands
// - per-port mode, unmasked port follows only global power commands
// - port count reported at bits 1 to 0, never above two
// - second register read with code 13h, written with code 93h
// - power mask at bits 18 to 16, bit 16 reserved
// - power mask disregarded while mode bit is zero
// - non-removable flags at bits 2 to 0, bit 0 reserved
// - first register read with code 12h, written with code 92h
// - per-port mode global power-on only powers unmasked ports
module rhpd_regs #(
    parameter int PORT_COUNT = 2,
    parameter logic RESET_NO_SWITCH = rhpd_pkg::RST_NO_SWITCH,
    parameter logic RESET_MODE_SEL = rhpd_pkg::RST_MODE_SEL,
    parameter logic [2:1] RESET_MASK = rhpd_pkg::RST_MASK,
    parameter logic [2:1] RESET_REMOVE = rhpd_pkg::RST_REMOVE
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic cmd_unknown,
    // power commands
    input wire logic ganged_power_on_cmd,
    input wire logic ganged_power_off_cmd,
    input wire logic [2:1] per_port_power_on_cmd,
    input wire logic [2:1] per_port_power_off_cmd,
    // configuration and state to the port logic
    output logic [2:1] port_power_state,
    output logic no_switching_flag,
    output logic switching_mode_select,
    output logic [1:0] downstream_port_count,
    output logic [2:0] per_port_power_mask,
    output logic [2:0] non_removable_flags
);
    // ==========================================================
    // declarations
    rhpd_pkg::rhpd_cmd_e cmd;
    logic no_switch;
    logic next_no_switch;
    logic mode_sel;
    logic next_mode_sel;
    logic [2:1] mask;
    logic [2:1] next_mask;
    logic [2:1] remove;
    logic [2:1] next_remove;
    logic next_rd_valid;
    logic [31:0] next_rd_data;
    logic next_cmd_unknown;
    logic [1:0] port_count;
    logic [31:0] first_value;
    logic [31:0] second_value;

    rhpd_power_if pw ();

    // ==========================================================
    // port count: fixed, clamped to the two ports the hub has
    assign port_count = (PORT_COUNT > rhpd_pkg::MAX_PORTS) ? rhpd_pkg::PORT_COUNT_LIMIT : 2'(PORT_COUNT);

    // ==========================================================
    // command decode
    always_comb begin
        cmd = rhpd_pkg::RHPD_CMD_NONE;
        if (cmd_valid) begin
            unique case (cmd_code)
                rhpd_pkg::CMD_RD_FIRST: begin
                    cmd = rhpd_pkg::RHPD_CMD_RD_FIRST;
                end
                rhpd_pkg::CMD_WR_FIRST: begin
                    cmd = rhpd_pkg::RHPD_CMD_WR_FIRST;
                end
                rhpd_pkg::CMD_RD_SECOND: begin
                    cmd = rhpd_pkg::RHPD_CMD_RD_SECOND;
                end
                rhpd_pkg::CMD_WR_SECOND: begin
                    cmd = rhpd_pkg::RHPD_CMD_WR_SECOND;
                end
                default: begin
                    cmd = rhpd_pkg::RHPD_CMD_NONE;
                end
            endcase
        end
    end

    // ==========================================================
    // read images; reserved and left-out bits read zero
    always_comb begin
        first_value = 32'h0;
        first_value[rhpd_pkg::NO_SWITCH_BIT] = no_switch;
        first_value[rhpd_pkg::MODE_SEL_BIT] = mode_sel;
        first_value[rhpd_pkg::PORT_COUNT_LSB +: rhpd_pkg::PORT_COUNT_W] = port_count;
        second_value = 32'h0;
        second_value[rhpd_pkg::MASK_LSB +: rhpd_pkg::PORT_FIELD_W] = {mask, 1'b0};
        second_value[rhpd_pkg::REMOVE_LSB +: rhpd_pkg::PORT_FIELD_W] = {remove, 1'b0};
    end

    // ==========================================================
    // register next values from writes
    always_comb begin
        next_no_switch = no_switch;
        next_mode_sel = mode_sel;
        next_mask = mask;
        next_remove = remove;
        unique case (cmd)
            rhpd_pkg::RHPD_CMD_WR_FIRST: begin
                // port count bits are read-only, reserved bits dropped
                next_no_switch = cmd_wdata[rhpd_pkg::NO_SWITCH_BIT];
                next_mode_sel = cmd_wdata[rhpd_pkg::MODE_SEL_BIT];
            end
            rhpd_pkg::RHPD_CMD_WR_SECOND: begin
                // bit 0 of each field is reserved and not stored
                next_mask = cmd_wdata[rhpd_pkg::MASK_LSB + 1 +: rhpd_pkg::MAX_PORTS];
                next_remove = cmd_wdata[rhpd_pkg::REMOVE_LSB + 1 +: rhpd_pkg::MAX_PORTS];
            end
            rhpd_pkg::RHPD_CMD_NONE, rhpd_pkg::RHPD_CMD_RD_FIRST, rhpd_pkg::RHPD_CMD_RD_SECOND: begin
                next_no_switch = no_switch;
            end
        endcase
    end

    // configuration registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            no_switch <= RESET_NO_SWITCH;
            mode_sel <= RESET_MODE_SEL;
            mask <= RESET_MASK;
            remove <= RESET_REMOVE;
        end else begin
            no_switch <= next_no_switch;
            mode_sel <= next_mode_sel;
            mask <= next_mask;
            remove <= next_remove;
        end
    end

    // ==========================================================
    // read data and command answer
    always_comb begin
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_cmd_unknown = cmd_valid && (cmd == rhpd_pkg::RHPD_CMD_NONE);
        unique case (cmd)
            rhpd_pkg::RHPD_CMD_RD_FIRST: begin
                next_rd_valid = 1'b1;
                next_rd_data = first_value;
            end
            rhpd_pkg::RHPD_CMD_RD_SECOND: begin
                next_rd_valid = 1'b1;
                next_rd_data = second_value;
            end
            rhpd_pkg::RHPD_CMD_NONE, rhpd_pkg::RHPD_CMD_WR_FIRST, rhpd_pkg::RHPD_CMD_WR_SECOND: begin
                next_rd_valid = 1'b0;
            end
        endcase
    end

    // answer registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid <= 1'b0;
            rd_data <= rhpd_pkg::RST_RD_DATA;
            cmd_unknown <= 1'b0;
        end else begin
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            cmd_unknown <= next_cmd_unknown;
        end
    end

    // ==========================================================
    // hookup to the power switch
    assign pw.no_switch = no_switch;
    assign pw.mode_sel = mode_sel;
    assign pw.mask = mask;
    assign pw.port_count = port_count;
    assign pw.ganged_on = ganged_power_on_cmd;
    assign pw.ganged_off = ganged_power_off_cmd;
    assign pw.port_on = per_port_power_on_cmd;
    assign pw.port_off = per_port_power_off_cmd;

    rhpd_power_switch u_switch (
        .clk(clk),
        .arst_n(arst_n),
        .pw(pw.sw)
    );

    // configuration and state outputs, all from flip-flops except the port count and bit 0 of the mask and flags, which are fixed values
    assign port_power_state = pw.power;
    assign no_switching_flag = no_switch;
    assign switching_mode_select = mode_sel;
    assign downstream_port_count = port_count;
    assign per_port_power_mask = {mask, 1'b0};
    assign non_removable_flags = {remove, 1'b0};

    // ==========================================================
    // checks
    a_first_write_taken: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_code == rhpd_pkg::CMD_WR_FIRST)
        |=> (no_switch == $past(cmd_wdata[rhpd_pkg::NO_SWITCH_BIT]))
            && (mode_sel == $past(cmd_wdata[rhpd_pkg::MODE_SEL_BIT])))
        else $error("first register write not stored");

    a_second_write_taken: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_code == rhpd_pkg::CMD_WR_SECOND)
        |=> (mask == $past(cmd_wdata[18:17])) ##0 (remove == $past(cmd_wdata[2:1])))
        else $error("second register write not stored");

    a_first_read_data: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_code == rhpd_pkg::CMD_RD_FIRST)
        |=> rd_valid && (rd_data[9] == no_switch) && (rd_data[8] == mode_sel)
            && (rd_data[31:10] == 22'h0) && (rd_data[7:2] == 6'h0))
        else $error("first register read wrong");

    a_second_read_data: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_code == rhpd_pkg::CMD_RD_SECOND)
        |=> rd_valid && (rd_data[18:16] == {mask, 1'b0}) && (rd_data[2:0] == {remove, 1'b0})
            && (rd_data[31:19] == 13'h0) && (rd_data[15:3] == 13'h0))
        else $error("second register read wrong");

    a_count_limit: assert property (@(posedge clk) disable iff (!arst_n)
        (downstream_port_count <= 2'h2) && $stable(downstream_port_count))
        else $error("port count out of range or changing");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        !per_port_power_mask[0] && !non_removable_flags[0])
        else $error("reserved field bit not zero");

    a_idle_holds: assert property (@(posedge clk) disable iff (!arst_n)
        !(cmd_valid && (cmd_code == rhpd_pkg::CMD_WR_FIRST || cmd_code == rhpd_pkg::CMD_WR_SECOND))
        |=> $stable(mask) && $stable(remove) && $stable(no_switch) && $stable(mode_sel))
        else $error("register changed without a write");

    a_read_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
        rd_valid |-> $past(cmd_valid) && ($past(cmd_code) == rhpd_pkg::CMD_RD_FIRST
            || $past(cmd_code) == rhpd_pkg::CMD_RD_SECOND))
        else $error("read answer without a read command");

    a_global_on_masked: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && mode_sel && ganged_power_on_cmd && (mask == 2'h3)
            && (per_port_power_on_cmd == 2'h0) && (per_port_power_off_cmd == 2'h0))
        |=> $stable(port_power_state))
        else $error("global power-on reached masked ports");

    a_ganged_mask_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && !mode_sel && ganged_power_off_cmd && !ganged_power_on_cmd)
        |=> (port_power_state == 2'h0))
        else $error("ganged power-off did not clear every port");

    // ==========================================================
    // command answers and port power checks
    a_unknown_flagged: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && (cmd_code != rhpd_pkg::CMD_RD_FIRST) && (cmd_code != rhpd_pkg::CMD_WR_FIRST)
            && (cmd_code != rhpd_pkg::CMD_RD_SECOND) && (cmd_code != rhpd_pkg::CMD_WR_SECOND))
        |=> cmd_unknown && !rd_valid)
        else $error("unmapped command not flagged");

    a_write_no_answer: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && (cmd_code == rhpd_pkg::CMD_WR_FIRST || cmd_code == rhpd_pkg::CMD_WR_SECOND))
        |=> !rd_valid && !cmd_unknown)
        else $error("write command answered");

    a_read_count: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd_code == rhpd_pkg::CMD_RD_FIRST)
        |=> (rd_data[1:0] == downstream_port_count))
        else $error("port count missing from first register read");

    a_read_data_holds: assert property (@(posedge clk) disable iff (!arst_n)
        !(cmd_valid && (cmd_code == rhpd_pkg::CMD_RD_FIRST || cmd_code == rhpd_pkg::CMD_RD_SECOND))
        |=> $stable(rd_data))
        else $error("read data changed without a read");

    a_masked_port_on: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && mode_sel && mask[1] && per_port_power_on_cmd[1] && (downstream_port_count != 2'h0))
        |=> port_power_state[1])
        else $error("per-port power-on ignored on masked port");

    a_masked_port_off: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && mode_sel && mask[2] && per_port_power_off_cmd[2] && !per_port_power_on_cmd[2])
        |=> !port_power_state[2])
        else $error("per-port power-off ignored on masked port");

    a_unmasked_port_on: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && mode_sel && !mask[1] && ganged_power_on_cmd && (downstream_port_count != 2'h0))
        |=> port_power_state[1])
        else $error("global power-on ignored on unmasked port");

    a_ganged_idle_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (!no_switch && !mode_sel && !ganged_power_on_cmd && !ganged_power_off_cmd)
        |=> $stable(port_power_state))
        else $error("ganged port power moved on a per-port command");

    a_no_switch_steady: assert property (@(posedge clk) disable iff (!arst_n)
        (no_switch && $past(no_switch))
        |=> $stable(port_power_state))
        else $error("port power moved with switching disabled");
endmodule

//--- verification/tb_root_hub_port_power_descriptor.sv
// self-checking bench for the root hub port power descriptor registers
`timescale 1ns/10ps
module tb_root_hub_port_power_descriptor;
    // ==========================================================
    // design signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [31:0] cmd_wdata = 32'h0;
    logic rd_valid;
    logic [31:0] rd_data;
    logic cmd_unknown;
    logic g_on = 1'b0;
    logic g_off = 1'b0;
    logic [2:1] p_on = 2'h0;
    logic [2:1] p_off = 2'h0;
    logic [2:1] port_power_state;
    logic no_switching_flag;
    logic switching_mode_select;
    logic [1:0] downstream_port_count;
    logic [2:0] per_port_power_mask;
    logic [2:0] non_removable_flags;

    // ==========================================================
    // bench state
    int n_mismatch = 0;
    int compares = 0;
    int n_unk_seen = 0;
    int n_unk_exp = 0;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr = 32'ha51fae5b;
    logic nps_m = 1'b0;
    logic mode_m = 1'b0;
    logic [2:1] mask_m = 2'h0;
    logic [2:1] rem_m = 2'h0;

    rhpd_regs #(
        .PORT_COUNT(2),
        .RESET_NO_SWITCH(1'h0),
        .RESET_MODE_SEL(1'h0),
        .RESET_MASK(2'h0),
        .RESET_REMOVE(2'h0)
    ) u_dut (
        .clk(clk),
        .arst_n(arst_n),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .cmd_unknown(cmd_unknown),
        .ganged_power_on_cmd(g_on),
        .ganged_power_off_cmd(g_off),
        .per_port_power_on_cmd(p_on),
        .per_port_power_off_cmd(p_off),
        .port_power_state(port_power_state),
        .no_switching_flag(no_switching_flag),
        .switching_mode_select(switching_mode_select),
        .downstream_port_count(downstream_port_count),
        .per_port_power_mask(per_port_power_mask),
        .non_removable_flags(non_removable_flags)
    );

    // 50 mhz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_first();
        return {22'h0, nps_m, mode_m, 6'h0, 2'h2};
    endfunction

    function automatic logic [31:0] exp_second();
        return {13'h0, mask_m, 1'b0, 13'h0, rem_m, 1'b0};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one command word, left asserted so the next can follow back to back
    task automatic issue(input logic [7:0] code, input logic [31:0] wdata);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= wdata;
    endtask

    // release all strobes, then let n edges pass
    task automatic idle(input int n);
        @(posedge clk);
        cmd_valid <= 1'b0;
        g_on <= 1'b0;
        g_off <= 1'b0;
        p_on <= 2'h0;
        p_off <= 2'h0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_first(input logic [31:0] w);
        issue(rhpd_pkg::CMD_WR_FIRST, w);
        nps_m = w[9];
        mode_m = w[8];
    endtask

    task automatic wr_second(input logic [31:0] w);
        issue(rhpd_pkg::CMD_WR_SECOND, w);
        mask_m = w[18:17];
        rem_m = w[2:1];
    endtask

    task automatic rd_first();
        issue(rhpd_pkg::CMD_RD_FIRST, ~lfsr);
        exp_q.push_back(exp_first());
    endtask

    task automatic rd_second();
        issue(rhpd_pkg::CMD_RD_SECOND, lfsr);
        exp_q.push_back(exp_second());
    endtask

    // one cycle of power commands, then the resulting port state
    task automatic pwr(input logic on, input logic off, input logic [2:1] pon, input logic [2:1] poff,
                       input logic [2:1] exp);
        @(posedge clk);
        g_on <= on;
        g_off <= off;
        p_on <= pon;
        p_off <= poff;
        idle(1);
        check({30'h0, port_power_state}, {30'h0, exp}, "port power state");
    endtask

    // ==========================================================
    // read answer watcher
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0, "read answer without read");
            end else begin
                check(rd_data, exp_q.pop_front(), "read data");
            end
        end
        if (cmd_unknown === 1'b1) begin
            n_unk_seen++;
        end
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        test_done();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check({30'h0, port_power_state}, 32'h0, "reset power");
        check({30'h0, downstream_port_count}, 32'h2, "port count");
        rd_first();
        rd_second();
        // random words, each write followed at once by its read
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_first(lfsr);
            rd_first();
            lfsr = lfsr_next(lfsr);
            wr_second(lfsr);
            rd_second();
            idle(1);
            check({29'h0, per_port_power_mask}, {29'h0, mask_m, 1'b0}, "mask out");
            check({29'h0, non_removable_flags}, {29'h0, rem_m, 1'b0}, "removable out");
            check({30'h0, no_switching_flag, switching_mode_select}, {30'h0, nps_m, mode_m}, "mode out");
        end
        // unmapped codes flagged and answered by no read
        issue(8'h14, 32'h0);
        issue(8'h00, 32'h0);
        n_unk_exp += 2;
        idle(2);
        // ganged mode with every mask bit set
        wr_first(32'h0);
        wr_second(32'hffff_ffff);
        rd_second();
        idle(1);
        pwr(1'b0, 1'b1, 2'h0, 2'h0, 2'b00);
        pwr(1'b1, 1'b0, 2'h0, 2'h0, 2'b11);
        pwr(1'b0, 1'b0, 2'h0, 2'b01, 2'b11);
        pwr(1'b0, 1'b1, 2'h0, 2'h0, 2'b00);
        pwr(1'b0, 1'b0, 2'b11, 2'h0, 2'b00);
        pwr(1'b1, 1'b1, 2'h0, 2'h0, 2'b11);
        pwr(1'b0, 1'b1, 2'h0, 2'h0, 2'b00);
        // per-port mode, port two masked
        wr_second(32'h0004_0000);
        wr_first(32'h0000_0100);
        rd_first();
        idle(1);
        pwr(1'b1, 1'b0, 2'h0, 2'h0, 2'b01);
        pwr(1'b0, 1'b0, 2'b10, 2'h0, 2'b11);
        pwr(1'b0, 1'b1, 2'h0, 2'h0, 2'b10);
        pwr(1'b0, 1'b0, 2'h0, 2'b10, 2'b00);
        pwr(1'b0, 1'b0, 2'b01, 2'h0, 2'b00);
        // both ports masked: global power-on reaches none
        wr_second(32'h0006_0000);
        idle(1);
        pwr(1'b1, 1'b0, 2'h0, 2'h0, 2'b00);
        pwr(1'b0, 1'b0, 2'b01, 2'h0, 2'b01);
        // no switching overrides everything, mode bit ignored
        wr_first(32'h0000_0300);
        idle(2);
        check({30'h0, port_power_state}, 32'h3, "always powered");
        pwr(1'b0, 1'b1, 2'h0, 2'b11, 2'b11);
        wr_first(32'h0);
        idle(1);
        pwr(1'b0, 1'b1, 2'h0, 2'h0, 2'b00);
        // drain outstanding reads
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) begin
            @(posedge clk);
        end
        check(exp_q.size(), 32'h0, "reads unanswered");
        check(n_unk_seen, n_unk_exp, "unknown code flags");
        test_done();
    end
endmodule
